/* File: hdl/fpr_sequencer.sv */
// Operation
// RQ1 - program entry key then nine, nine starts the full reset sequence
// RQ2 - first step shows the reset announcement message
// RQ3 - then all segments and lamps lit for the lamp test, then off
// RQ4 - during lamp test run rom checksum and ram self test
// RQ5 - after lamps off show firmware revision for about half a second
// RQ6 - then show bus address for about half a second; defaults then apply
// RQ7 - open every relay channel and show default channel indication
// RQ8 - leave time, date and the reset key function unchanged
// RQ9 - scan interval becomes 000.010
// RQ10 - continuous and single scan inactive, start/stop stopped
// RQ11 - digital outputs to 000, digital inputs untouched
// RQ12 - date format month first
// RQ13 - relay settle time becomes 000.005 seconds
// RQ14 - bus address becomes 18
// RQ15 - pending save-setup selection cleared
// RQ16 - pending recall-setup selection cleared
// RQ17 - pole configuration becomes 2
// RQ18 - alarm time becomes 00.00.00
// RQ19 - self-test settings untouched
// RQ20 - inspect mode off, stored-location clear inactive
// RQ21 - first scan channel 1, last scan channel the highest installed
// RQ22 - in slave mode the full-reset request is ignored, nothing changes
// RQ23 - full reset ends an active inspect mode
// RQ24 - further key entries ignored until the address display step ends

`timescale 1ns/10ps
module fpr_sequencer #(
    parameter int ANNOUNCE_CYC = fpr_pkg::ANNOUNCE_CYC,
    parameter int LAMP_CYC = fpr_pkg::LAMP_CYC,
    parameter int REV_CYC = fpr_pkg::REV_CYC,
    parameter int ADDR_CYC = fpr_pkg::ADDR_CYC,

    // revision code shown on the display; value is arbitrary
    parameter logic [7:0] FW_REVISION = 8'h10
) (
    input wire logic clk_in,
    input wire logic nrst_in,

    input wire logic key_valid_in,
    input wire logic [3:0] key_code_in,
    input wire logic slave_mode_in,
    input wire logic [fpr_pkg::CHAN_W-1:0] max_chan_in,

    input wire logic [7:0] rom_data_in,
    input wire logic [15:0] rom_crc_expect_in,
    input wire logic [7:0] ram_rdata_in,

    output logic [fpr_pkg::ROM_AW-1:0] rom_addr_out,

    output logic [fpr_pkg::RAM_AW-1:0] ram_addr_out,
    output logic [7:0] ram_wdata_out,
    output logic ram_we_out,

    output fpr_pkg::fpr_disp_s disp_out,
    output logic talk_lamp_out,
    output logic listen_lamp_out,
    output logic remote_lamp_out,

    output logic relays_open_out,
    output logic defaults_load_out,
    output fpr_pkg::fpr_settings_s settings_out,

    output logic busy_out,
    output logic self_test_done_out,
    output logic rom_ok_out,
    output logic ram_ok_out
);

    typedef enum logic [2:0] {
        STEP_IDLE,
        STEP_ANNOUNCE,
        STEP_LAMP,
        STEP_REVISION,
        STEP_ADDRESS
    } fpr_step_e;

    typedef enum logic [1:0] {
        KEY_WAIT_PROG,
        KEY_WAIT_FIRST,
        KEY_WAIT_SECOND
    } fpr_key_e;

    typedef struct packed {
        fpr_step_e step;
        fpr_key_e keys;

        logic [31:0] tmr;

        logic tests_go;
        logic load;
        logic relays_open;

        logic tested;
        logic rom_ok;
        logic ram_ok;

        fpr_pkg::fpr_disp_s disp;
        fpr_pkg::fpr_settings_s set;
    } fpr_seq_st_s;

    fpr_seq_st_s st_reg;
    fpr_seq_st_s st_next;

    logic key_taken;
    logic start_req;

    logic rom_done;
    logic rom_pass;

    logic ram_done;
    logic ram_pass;

    // timer holds cycles left minus one; zero means the step is over
    function automatic logic [31:0] tmr_load(input int cycles);
        return (cycles > 1) ? 32'(cycles - 1) : 32'h00000000;
    endfunction

    function automatic fpr_pkg::fpr_settings_s default_settings(
        input fpr_pkg::fpr_settings_s cur,
        input logic [fpr_pkg::CHAN_W-1:0] top_chan
    );
        fpr_pkg::fpr_settings_s s;

        s = cur;

        s.interval_ms = fpr_pkg::DEF_INTERVAL_MS; // RQ9

        s.cont_scan = 1'b0; // RQ10
        s.single_scan = 1'b0; // RQ10
        s.scan_running = 1'b0; // RQ10

        s.dig_out = fpr_pkg::DEF_DIG_OUT; // RQ11

        s.date_month_first = 1'b1; // RQ12

        s.settle_ms = fpr_pkg::DEF_SETTLE_MS; // RQ13

        s.bus_addr = fpr_pkg::DEF_BUS_ADDR; // RQ14

        s.save_pending = 1'b0; // RQ15

        s.recall_pending = 1'b0; // RQ16

        s.poles = fpr_pkg::DEF_POLES; // RQ17

        s.alarm_bcd = fpr_pkg::DEF_ALARM_BCD; // RQ18

        s.inspect_on = 1'b0; // RQ20 RQ23
        s.clear_active = 1'b0; // RQ20

        s.first_chan = fpr_pkg::DEF_FIRST_CHAN; // RQ21
        s.last_chan = top_chan; // RQ21

        return s;
    endfunction

    // program key, nine, nine; other keys restart the match
    assign key_taken = key_valid_in && st_reg.step == STEP_IDLE && !slave_mode_in; // RQ22 RQ24
    assign start_req = key_taken && st_reg.keys == KEY_WAIT_SECOND
        && key_code_in == fpr_pkg::KEY_DIGIT_NINE; // RQ1

    always_comb begin
        st_next = st_reg;

        st_next.tests_go = 1'b0;
        st_next.load = 1'b0;
        st_next.relays_open = 1'b0;

        if (st_reg.tmr != 32'h00000000) begin
            st_next.tmr = st_reg.tmr - 32'h00000001;
        end

        // keys are only parsed while idle and not a slave unit
        if (key_taken) begin // RQ22 RQ24
            if (key_code_in == fpr_pkg::KEY_PROGRAM_ENTRY) begin
                st_next.keys = KEY_WAIT_FIRST; // RQ1
            end else if (key_code_in == fpr_pkg::KEY_DIGIT_NINE
                         && st_reg.keys == KEY_WAIT_FIRST) begin
                st_next.keys = KEY_WAIT_SECOND; // RQ1
            end else begin
                st_next.keys = KEY_WAIT_PROG;
            end
        end

        unique case (st_reg.step)
            STEP_IDLE: begin
                if (start_req) begin
                    st_next.step = STEP_ANNOUNCE;
                    st_next.keys = KEY_WAIT_PROG;
                    st_next.tmr = tmr_load(ANNOUNCE_CYC);

                    st_next.disp.mode = fpr_pkg::DISP_RESET_MSG; // RQ2
                    st_next.disp.value = 8'h00;
                    st_next.disp.all_lamps = 1'b0;
                end
            end

            STEP_ANNOUNCE: begin
                if (st_reg.tmr == 32'h00000000) begin
                    st_next.step = STEP_LAMP;
                    st_next.tmr = tmr_load(LAMP_CYC);

                    st_next.tests_go = 1'b1; // RQ4
                    st_next.tested = 1'b0;

                    st_next.disp.mode = fpr_pkg::DISP_ALL_ON; // RQ3
                    st_next.disp.all_lamps = 1'b1; // RQ3
                end
            end

            STEP_LAMP: begin
                // the lamps stay lit until both tests finish, even past the interval
                if (st_reg.tmr == 32'h00000000 && rom_done && ram_done
                    && !st_reg.tests_go) begin // RQ4
                    st_next.step = STEP_REVISION;
                    st_next.tmr = tmr_load(REV_CYC);

                    st_next.tested = 1'b1;
                    st_next.rom_ok = rom_pass;
                    st_next.ram_ok = ram_pass;

                    st_next.disp.all_lamps = 1'b0; // RQ3
                    st_next.disp.mode = fpr_pkg::DISP_REVISION; // RQ5
                    st_next.disp.value = FW_REVISION; // RQ5
                end
            end

            STEP_REVISION: begin
                if (st_reg.tmr == 32'h00000000) begin
                    st_next.step = STEP_ADDRESS;
                    st_next.tmr = tmr_load(ADDR_CYC);

                    st_next.disp.mode = fpr_pkg::DISP_ADDRESS; // RQ6
                    st_next.disp.value = {3'h0, fpr_pkg::DEF_BUS_ADDR}; // RQ6
                end
            end

            STEP_ADDRESS: begin
                if (st_reg.tmr == 32'h00000000) begin
                    st_next.step = STEP_IDLE; // RQ24
                    st_next.load = 1'b1; // RQ6
                    st_next.relays_open = 1'b1; // RQ7

                    st_next.disp.mode = fpr_pkg::DISP_NORMAL; // RQ7
                    st_next.disp.value = fpr_pkg::DEF_CHAN_SHOWN; // RQ7

                    // time, date, reset key and self-test setup live elsewhere
                    st_next.set = default_settings(st_reg.set, max_chan_in); // RQ8 RQ19
                end
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            st_reg.step <= STEP_IDLE;

            st_reg.keys <= KEY_WAIT_PROG;

            st_reg.tmr <= 32'h00000000;

            st_reg.tests_go <= 1'b0;
            st_reg.load <= 1'b0;
            st_reg.relays_open <= 1'b0;

            st_reg.tested <= 1'b0;
            st_reg.rom_ok <= 1'b0;
            st_reg.ram_ok <= 1'b0;

            st_reg.disp.mode <= fpr_pkg::DISP_NORMAL;
            st_reg.disp.value <= fpr_pkg::DEF_CHAN_SHOWN;
            st_reg.disp.all_lamps <= 1'b0;

            // power-up settings match the full-reset defaults, last channel zero
            st_reg.set <= '{
                interval_ms: fpr_pkg::DEF_INTERVAL_MS,
                settle_ms: fpr_pkg::DEF_SETTLE_MS,
                bus_addr: fpr_pkg::DEF_BUS_ADDR,
                poles: fpr_pkg::DEF_POLES,
                alarm_bcd: fpr_pkg::DEF_ALARM_BCD,
                dig_out: fpr_pkg::DEF_DIG_OUT,
                first_chan: fpr_pkg::DEF_FIRST_CHAN,
                last_chan: '0,
                date_month_first: 1'b1,
                default: 1'b0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    fpr_rom_crc u_rom_crc (
        .clk_in(clk_in),
        .nrst_in(nrst_in),

        .start_in(st_reg.tests_go),

        .rom_data_in(rom_data_in),
        .expect_in(rom_crc_expect_in),

        .rom_addr_out(rom_addr_out),
        .done_out(rom_done),
        .ok_out(rom_pass)
    );

    fpr_ram_test u_ram_test (
        .clk_in(clk_in),
        .nrst_in(nrst_in),

        .start_in(st_reg.tests_go),

        .ram_rdata_in(ram_rdata_in),

        .ram_addr_out(ram_addr_out),
        .ram_wdata_out(ram_wdata_out),
        .ram_we_out(ram_we_out),
        .done_out(ram_done),
        .ok_out(ram_pass)
    );

    assign disp_out = st_reg.disp;

    assign talk_lamp_out = st_reg.disp.all_lamps; // RQ3
    assign listen_lamp_out = st_reg.disp.all_lamps; // RQ3
    assign remote_lamp_out = st_reg.disp.all_lamps; // RQ3

    assign relays_open_out = st_reg.relays_open;
    assign defaults_load_out = st_reg.load;

    assign settings_out = st_reg.set;

    assign busy_out = (st_reg.step != STEP_IDLE);

    assign self_test_done_out = st_reg.tested;
    assign rom_ok_out = st_reg.rom_ok;
    assign ram_ok_out = st_reg.ram_ok;
endmodule // fpr_sequencer

/* File: hdl/fpr_pkg.sv */
package fpr_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int ANNOUNCE_MS = 500;
    localparam int LAMP_MS = 1000;
    localparam int REV_MS = 500;
    localparam int ADDR_MS = 500;
    localparam int ANNOUNCE_CYC = ANNOUNCE_MS * CYC_PER_MS;
    localparam int LAMP_CYC = LAMP_MS * CYC_PER_MS;
    localparam int REV_CYC = REV_MS * CYC_PER_MS;
    localparam int ADDR_CYC = ADDR_MS * CYC_PER_MS;

    // key codes from the front panel scanner
    localparam logic [3:0] KEY_DIGIT_NINE = 4'h9;
    localparam logic [3:0] KEY_PROGRAM_ENTRY = 4'hA;

    localparam int CHAN_W = 7;
    localparam int ROM_AW = 12;
    localparam int RAM_AW = 11;

    // default operating state
    localparam logic [15:0] DEF_INTERVAL_MS = 16'h000A;
    localparam logic [15:0] DEF_SETTLE_MS = 16'h0005;
    localparam logic [4:0] DEF_BUS_ADDR = 5'h12;
    localparam logic [2:0] DEF_POLES = 3'h2;
    localparam logic [23:0] DEF_ALARM_BCD = 24'h000000;
    localparam logic [2:0] DEF_DIG_OUT = 3'h0;
    localparam logic [CHAN_W-1:0] DEF_FIRST_CHAN = 7'h01;
    localparam logic [7:0] DEF_CHAN_SHOWN = 8'h01;

    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [7:0] RAM_PATTERN = 8'h55;

    typedef enum logic [2:0] {
        DISP_NORMAL,
        DISP_RESET_MSG,
        DISP_ALL_ON,
        DISP_REVISION,
        DISP_ADDRESS
    } fpr_disp_e;

    typedef struct packed {
        fpr_disp_e mode;
        logic [7:0] value;
        logic all_lamps;
    } fpr_disp_s;

    typedef struct packed {
        logic [15:0] interval_ms;
        logic [15:0] settle_ms;
        logic [4:0] bus_addr;
        logic [2:0] poles;
        logic [23:0] alarm_bcd;
        logic [2:0] dig_out;
        logic [CHAN_W-1:0] first_chan;
        logic [CHAN_W-1:0] last_chan;
        logic date_month_first;
        logic cont_scan;
        logic single_scan;
        logic scan_running;
        logic save_pending;
        logic recall_pending;
        logic inspect_on;
        logic clear_active;
    } fpr_settings_s;
endpackage

/* File: hdl/fpr_rom_crc.sv */
`timescale 1ns/10ps
module fpr_rom_crc (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic start_in,
    input wire logic [7:0] rom_data_in,
    input wire logic [15:0] expect_in,
    output logic [fpr_pkg::ROM_AW-1:0] rom_addr_out,
    output logic done_out,
    output logic ok_out
);
    typedef struct packed {
        logic run;
        logic vld;
        logic [fpr_pkg::ROM_AW-1:0] addr;
        logic [15:0] crc;
        logic done;
        logic ok;
    } fpr_crc_st_s;

    fpr_crc_st_s st_reg;
    fpr_crc_st_s st_next;
    logic [15:0] crc_upd;

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ fpr_pkg::CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    always_comb begin
        st_next = st_reg;
        st_next.vld = 1'b0;
        crc_upd = crc_byte(st_reg.crc, rom_data_in);
        // rom read has one cycle of latency, so data trails the address by one
        if (st_reg.vld) begin
            st_next.crc = crc_upd;
            if (!st_reg.run) begin
                st_next.done = 1'b1;
                st_next.ok = (crc_upd == expect_in);
            end
        end
        if (st_reg.run) begin
            st_next.vld = 1'b1;
            if (&st_reg.addr) begin
                st_next.run = 1'b0;
            end else begin
                st_next.addr = st_reg.addr + 1'b1;
            end
        end
        if (start_in) begin
            st_next.run = 1'b1;
            st_next.vld = 1'b0;
            st_next.addr = '0;
            st_next.crc = fpr_pkg::CRC_INIT;
            st_next.done = 1'b0;
            st_next.ok = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rom_addr_out = st_reg.addr;
    assign done_out = st_reg.done;
    assign ok_out = st_reg.ok;
endmodule // fpr_rom_crc

/* File: hdl/fpr_ram_test.sv */
`timescale 1ns/10ps
module fpr_ram_test (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic start_in,
    input wire logic [7:0] ram_rdata_in,
    output logic [fpr_pkg::RAM_AW-1:0] ram_addr_out,
    output logic [7:0] ram_wdata_out,
    output logic ram_we_out,
    output logic done_out,
    output logic ok_out
);
    typedef struct packed {
        logic wr;
        logic rd;
        logic vld;
        logic [fpr_pkg::RAM_AW-1:0] addr;
        logic [fpr_pkg::RAM_AW-1:0] vaddr;
        logic [7:0] wdata;
        logic we;
        logic done;
        logic ok;
    } fpr_ram_st_s;

    fpr_ram_st_s st_reg;
    fpr_ram_st_s st_next;

    // pattern built from address bits 7:0 catches stuck and shorted lines among those eight address bits only
    function automatic logic [7:0] pattern(input logic [fpr_pkg::RAM_AW-1:0] a);
        return a[7:0] ^ fpr_pkg::RAM_PATTERN;
    endfunction

    always_comb begin
        st_next = st_reg;
        st_next.vld = 1'b0;
        st_next.we = 1'b0;
        if (st_reg.vld) begin
            if (ram_rdata_in != pattern(st_reg.vaddr)) begin
                st_next.ok = 1'b0;
            end
            if (!st_reg.rd) begin
                st_next.done = 1'b1;
            end
        end
        if (st_reg.wr) begin
            st_next.we = 1'b1;
            st_next.wdata = pattern(st_next.addr);
            if (st_reg.we && &st_reg.addr) begin
                st_next.wr = 1'b0;
                st_next.we = 1'b0;
                st_next.rd = 1'b1;
                st_next.addr = '0;
            end else if (st_reg.we) begin
                st_next.addr = st_reg.addr + 1'b1;
                st_next.wdata = pattern(st_reg.addr + 1'b1);
            end
        end else if (st_reg.rd) begin
            st_next.vld = 1'b1;
            st_next.vaddr = st_reg.addr;
            if (&st_reg.addr) begin
                st_next.rd = 1'b0;
            end else begin
                st_next.addr = st_reg.addr + 1'b1;
            end
        end
        if (start_in) begin
            st_next = '0;
            st_next.wr = 1'b1;
            st_next.ok = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ram_addr_out = st_reg.addr;
    assign ram_wdata_out = st_reg.wdata;
    assign ram_we_out = st_reg.we;
    assign done_out = st_reg.done;
    assign ok_out = st_reg.ok;
endmodule // fpr_ram_test

/* File: sim/fpr_panel_model.sv */
`timescale 1ns/10ps
module fpr_panel_model (
    input wire logic clk_in,
    input wire logic ram_fault_in,
    input wire logic [fpr_pkg::ROM_AW-1:0] rom_addr_in,
    input wire logic [fpr_pkg::RAM_AW-1:0] ram_addr_in,
    input wire logic [7:0] ram_wdata_in,
    input wire logic ram_we_in,
    output logic [7:0] rom_data_out,
    output logic [7:0] ram_rdata_out
);
    logic [7:0] ram_mem [0:2047];

    // memories behind the power-up checks, one cycle read latency
    always @(posedge clk_in) begin
        rom_data_out <= rom_addr_in[7:0] ^ {rom_addr_in[11:8], rom_addr_in[11:8]};
        if (ram_we_in) begin
            ram_mem[ram_addr_in] <= ram_wdata_in;
        end
        // bit 0 of every ram read is inverted while ram_fault_in is set, so the bench sees the memory check fail
        ram_rdata_out <= ram_mem[ram_addr_in] ^ {7'h00, ram_fault_in};
    end
endmodule // fpr_panel_model

/* File: sim/fpr_sequencer_properties.sv */
`timescale 1ns/10ps
module fpr_sequencer_checker #(
    parameter int ANNOUNCE_CYC = 10,
    parameter int LAMP_CYC = 20,
    parameter int REV_CYC = 10,
    parameter int ADDR_CYC = 10,
    parameter logic [7:0] FW_REVISION = 8'h10
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic key_valid_in,
    input wire logic [3:0] key_code_in,
    input wire logic slave_mode_in,
    input wire logic [fpr_pkg::CHAN_W-1:0] max_chan_in,
    input wire fpr_pkg::fpr_disp_s disp_out,
    input wire logic talk_lamp_out,
    input wire logic listen_lamp_out,
    input wire logic remote_lamp_out,
    input wire logic relays_open_out,
    input wire logic defaults_load_out,
    input wire fpr_pkg::fpr_settings_s settings_out,
    input wire logic busy_out,
    input wire logic self_test_done_out
);
    fpr_pkg::fpr_disp_e prev_mode;
    int run_len;
    logic key_ok;
    logic step;

    assign key_ok = key_valid_in && !busy_out && !slave_mode_in;
    assign step = disp_out.mode != prev_mode;

    // cycles spent in the current display step
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            prev_mode <= fpr_pkg::DISP_NORMAL;
            run_len <= 0;
        end else begin
            prev_mode <= disp_out.mode;
            run_len <= step ? 1 : run_len + 1;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    key_start_a: assert property ((key_ok && key_code_in == fpr_pkg::KEY_PROGRAM_ENTRY) ##1
        (key_ok && key_code_in == 4'h9) ##1 (key_ok && key_code_in == 4'h9)
        |=> busy_out && disp_out.mode == fpr_pkg::DISP_RESET_MSG) else $error("start missed");
    slave_block_a: assert property (!busy_out && !key_ok |=> !busy_out)
        else $error("sequence started without a taken key");
    step_order_a: assert property (step |-> disp_out.mode ==
        (prev_mode == fpr_pkg::DISP_ADDRESS ? fpr_pkg::DISP_NORMAL : prev_mode + 3'h1))
        else $error("display step out of order");
    lamp_follow_a: assert property ((disp_out.mode == fpr_pkg::DISP_ALL_ON) == disp_out.all_lamps
        && {talk_lamp_out, listen_lamp_out, remote_lamp_out} == {3{disp_out.all_lamps}})
        else $error("lamps disagree with lamp test step");
    announce_len_a: assert property (step && prev_mode == fpr_pkg::DISP_RESET_MSG
        |-> run_len == ANNOUNCE_CYC) else $error("announcement length wrong");
    lamp_len_a: assert property (step && prev_mode == fpr_pkg::DISP_ALL_ON
        |-> run_len >= LAMP_CYC) else $error("lamp test too short");
    rev_len_a: assert property (step && prev_mode == fpr_pkg::DISP_REVISION
        |-> run_len == REV_CYC) else $error("revision display length wrong");
    addr_len_a: assert property (step && prev_mode == fpr_pkg::DISP_ADDRESS
        |-> run_len == ADDR_CYC) else $error("address display length wrong");
    rev_show_a: assert property (disp_out.mode == fpr_pkg::DISP_REVISION
        |-> disp_out.value == FW_REVISION && self_test_done_out) else $error("revision bad");
    addr_show_a: assert property (disp_out.mode == fpr_pkg::DISP_ADDRESS
        |-> disp_out.value == 8'h12) else $error("address display value wrong");
    apply_once_a: assert property (defaults_load_out |-> relays_open_out && !busy_out
        && prev_mode == fpr_pkg::DISP_ADDRESS && settings_out.bus_addr == 5'h12
        && settings_out.last_chan == max_chan_in && !settings_out.inspect_on
        ##1 !defaults_load_out && !relays_open_out) else $error("default apply wrong");
    settings_hold_a: assert property (!defaults_load_out |-> $stable(settings_out))
        else $error("settings moved outside the apply cycle");

    cover property ($rose(busy_out));
    cover property (defaults_load_out);
    cover property (slave_mode_in && key_valid_in);
endmodule // fpr_sequencer_checker

bind fpr_sequencer fpr_sequencer_checker #(.ANNOUNCE_CYC(ANNOUNCE_CYC), .LAMP_CYC(LAMP_CYC),
    .REV_CYC(REV_CYC), .ADDR_CYC(ADDR_CYC), .FW_REVISION(FW_REVISION)) u_check (
    .clk_in(clk_in), .nrst_in(nrst_in), .key_valid_in(key_valid_in),
    .key_code_in(key_code_in), .slave_mode_in(slave_mode_in), .max_chan_in(max_chan_in),
    .disp_out(disp_out), .talk_lamp_out(talk_lamp_out), .listen_lamp_out(listen_lamp_out),
    .remote_lamp_out(remote_lamp_out), .relays_open_out(relays_open_out),
    .defaults_load_out(defaults_load_out), .settings_out(settings_out),
    .busy_out(busy_out), .self_test_done_out(self_test_done_out));

/* File: sim/fpr_sequencer_test.sv */
`timescale 1ns/10ps
module fpr_sequencer_test;
    localparam logic [7:0] FW_REV = 8'h3C; // arbitrary revision code
    logic clk, nrst, key_valid, slave, ram_fault, ram_we, talk, listen, remote;
    logic relays_open, defaults_load, busy, st_done, rom_ok, ram_ok;
    logic [3:0] key_code;
    logic [6:0] max_chan;
    logic [15:0] crc_expect;
    logic [7:0] rom_data, ram_rdata, ram_wdata;
    logic [11:0] rom_addr;
    logic [10:0] ram_addr;
    fpr_pkg::fpr_disp_s disp;
    fpr_pkg::fpr_settings_s settings;
    int fails = 0, tests_run = 0, cycles = 0;

    fpr_sequencer #(.ANNOUNCE_CYC(10), .LAMP_CYC(20), .REV_CYC(10), .ADDR_CYC(10),
        .FW_REVISION(FW_REV)) uut (
        .clk_in(clk), .nrst_in(nrst), .key_valid_in(key_valid), .key_code_in(key_code),
        .slave_mode_in(slave), .max_chan_in(max_chan), .rom_data_in(rom_data),
        .rom_crc_expect_in(crc_expect), .ram_rdata_in(ram_rdata), .rom_addr_out(rom_addr),
        .ram_addr_out(ram_addr), .ram_wdata_out(ram_wdata), .ram_we_out(ram_we),
        .disp_out(disp), .talk_lamp_out(talk), .listen_lamp_out(listen),
        .remote_lamp_out(remote), .relays_open_out(relays_open),
        .defaults_load_out(defaults_load), .settings_out(settings), .busy_out(busy),
        .self_test_done_out(st_done), .rom_ok_out(rom_ok), .ram_ok_out(ram_ok));

    fpr_panel_model u_panel (.clk_in(clk), .ram_fault_in(ram_fault), .rom_addr_in(rom_addr),
        .ram_addr_in(ram_addr), .ram_wdata_in(ram_wdata), .ram_we_in(ram_we),
        .rom_data_out(rom_data), .ram_rdata_out(ram_rdata));

    always #10 clk = ~clk;

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    function automatic fpr_pkg::fpr_settings_s exp_set(input logic [6:0] top);
        return {16'h000A, 16'h0005, 5'h12, 3'h2, 24'h000000, 3'h0, 7'h01, top, 8'h80};
    endfunction

    function automatic logic [15:0] rom_crc();
        logic [15:0] c;
        logic [7:0] b;
        c = 16'hFFFF;
        for (int a = 0; a < 4096; a++) begin
            b = a[7:0] ^ {a[11:8], a[11:8]};
            c = c ^ {b, 8'h00};
            for (int i = 0; i < 8; i++) c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
        end
        return c;
    endfunction

    task automatic send_keys(input logic [11:0] seq);
        for (int i = 2; i >= 0; i--) begin
            @(posedge clk);
            key_valid <= 1'b1;
            key_code <= seq[i*4 +: 4];
        end
        @(posedge clk);
        key_valid <= 1'b0;
    endtask

    task automatic wait_mode(input fpr_pkg::fpr_disp_e m);
        int n = 0;
        while (disp.mode !== m && n < 20000) begin
            @(negedge clk);
            n++;
        end
        check(disp.mode, m);
    endtask

    task automatic run_seq(input logic [15:0] crc, input logic fault, input logic [6:0] top,
        input logic ok);
        int n = 0;
        @(posedge clk);
        crc_expect <= crc;
        ram_fault <= fault;
        max_chan <= top;
        send_keys(12'hA99);
        @(negedge clk);
        check({busy, disp.mode}, {1'b1, fpr_pkg::DISP_RESET_MSG});
        send_keys(12'hA99);
        wait_mode(fpr_pkg::DISP_ALL_ON);
        check({disp.all_lamps, talk, listen, remote}, 4'hF);
        wait_mode(fpr_pkg::DISP_REVISION);
        check({disp.value, disp.all_lamps, talk, listen, remote}, {FW_REV, 4'h0});
        check({st_done, rom_ok, ram_ok}, {1'b1, ok, ok});
        while (disp.mode === fpr_pkg::DISP_REVISION) begin
            n++;
            @(negedge clk);
        end
        check(n, 10);
        check({disp.mode, disp.value}, {fpr_pkg::DISP_ADDRESS, 8'h12});
        n = 0;
        while (disp.mode === fpr_pkg::DISP_ADDRESS) begin
            n++;
            @(negedge clk);
        end
        check(n, 10);
        check({relays_open, defaults_load, busy}, 3'b110);
        check(disp, {fpr_pkg::DISP_NORMAL, 8'h01, 1'b0});
        check(settings, exp_set(top));
        @(negedge clk);
        check({relays_open, defaults_load}, 2'b00);
    endtask

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        key_valid = 1'b0;
        key_code = 4'h0;
        slave = 1'b0;
        ram_fault = 1'b0;
        max_chan = 7'h50;
        crc_expect = 16'h0000;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        check(settings, exp_set(7'h00));
        check({busy, relays_open, disp.mode}, {2'b00, fpr_pkg::DISP_NORMAL});
        @(posedge clk);
        slave <= 1'b1;
        send_keys(12'hA99);
        repeat (3) @(negedge clk);
        check({busy, disp.mode}, {1'b0, fpr_pkg::DISP_NORMAL});
        check(settings, exp_set(7'h00));
        @(posedge clk);
        slave <= 1'b0;
        send_keys(12'hA93);
        repeat (2) @(negedge clk);
        check(busy, 1'b0);
        run_seq(rom_crc(), 1'b0, 7'h50, 1'b1);
        run_seq(~rom_crc(), 1'b1, 7'h1F, 1'b0);
        print_verdict();
    end
endmodule // fpr_sequencer_test
